// ==== flash_front_pkg.sv ====
package flash_front_pkg;

    localparam int         ADDR_BITS       = 24;
    localparam int         BYTE_BITS       = 8;
    localparam int         FIFO_DEPTH      = 8;

    localparam logic [7:0] OPC_READ        = 8'h03;
    localparam logic [7:0] OPC_FAST_READ   = 8'h0B;
    localparam logic [7:0] OPC_DUAL_OUT    = 8'h3B;
    localparam logic [7:0] OPC_QUAD_OUT    = 8'h6B;
    localparam logic [7:0] OPC_QUAD_IO     = 8'hEB;

    localparam logic [4:0] CLKS_BYTE       = 5'h08;
    localparam logic [4:0] CLKS_ADDR_X1    = 5'h18;
    localparam logic [4:0] CLKS_ADDR_X4    = 5'h06;
    localparam logic [4:0] CLKS_MODE_X4    = 5'h02;
    localparam logic [4:0] CLKS_DUMMY_FAST = 5'h08;
    localparam logic [4:0] CLKS_DUMMY_QIO  = 5'h04;

    localparam int         XIP_KEY_LSB     = 4;
    localparam logic [1:0] XIP_KEY         = 2'h2;
    localparam logic [7:0] UNDERRUN_FILL   = 8'hFF;

    typedef enum logic [1:0] {
        EV_READ,
        EV_OPCODE,
        EV_WBYTE
    } event_kind_t;

    typedef enum logic [2:0] {
        ST_START,
        ST_OPCODE,
        ST_ADDR,
        ST_MODE,
        ST_DUMMY,
        ST_DATA,
        ST_WBYTE,
        ST_IGNORE
    } link_state_t;

    typedef struct packed {
        event_kind_t           kind;
        logic [7:0]            opcode;
        logic [ADDR_BITS-1:0]  addr;
        logic [BYTE_BITS-1:0]  data;
    } link_event_t;

endpackage

// ==== cdc_fifo.sv ====
`timescale 1ns/1ps
module cdc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             wr_clk_in,
    input  wire logic             wr_rst_b_in,
    input  wire logic             wr_clear_in,
    input  wire logic             wr_valid_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  wr_ready_out,
    input  wire logic             rd_clk_in,
    input  wire logic             rd_rst_b_in,
    input  wire logic             rd_ready_in,
    output logic                  rd_valid_out,
    output logic [WIDTH-1:0]      rd_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wbin_ff;
    logic [AW:0]      nxt_wbin;
    logic [AW:0]      rbin_ff;
    logic [AW:0]      nxt_rbin;
    logic [AW:0]      wgray;
    logic [AW:0]      rgray;
    logic [AW:0]      rgray_meta_ff;
    logic [AW:0]      rgray_sync_ff;
    logic [AW:0]      wgray_meta_ff;
    logic [AW:0]      wgray_sync_ff;

    assign wgray        = wbin_ff ^ (wbin_ff >> 1);
    assign rgray        = rbin_ff ^ (rbin_ff >> 1);
    assign wr_ready_out = !wr_clear_in &&
                          (wgray != {~rgray_sync_ff[AW:AW-1], rgray_sync_ff[AW-2:0]});
    assign rd_valid_out = (rgray != wgray_sync_ff);
    assign rd_data_out  = mem_ff[rbin_ff[AW-1:0]];

    always_comb begin
        nxt_wbin = wbin_ff;
        if (wr_clear_in) begin
            nxt_wbin = '0;
        end else if (wr_valid_in && wr_ready_out) begin
            nxt_wbin = wbin_ff + 1'b1;
        end
    end

    always_ff @(posedge wr_clk_in or negedge wr_rst_b_in) begin
        if (!wr_rst_b_in) begin
            wbin_ff       <= '0;
            rgray_meta_ff <= '0;
            rgray_sync_ff <= '0;
        end else begin
            wbin_ff       <= nxt_wbin;
            rgray_meta_ff <= rgray;
            rgray_sync_ff <= rgray_meta_ff;
        end
    end

    always_ff @(posedge wr_clk_in) begin
        if (wr_valid_in && wr_ready_out) begin
            mem_ff[wbin_ff[AW-1:0]] <= wr_data_in;
        end
    end

    always_comb begin
        nxt_rbin = rbin_ff;
        if (rd_ready_in && rd_valid_out) begin
            nxt_rbin = rbin_ff + 1'b1;
        end
    end

    always_ff @(posedge rd_clk_in or negedge rd_rst_b_in) begin
        if (!rd_rst_b_in) begin
            rbin_ff       <= '0;
            wgray_meta_ff <= '0;
            wgray_sync_ff <= '0;
        end else begin
            rbin_ff       <= nxt_rbin;
            wgray_meta_ff <= wgray;
            wgray_sync_ff <= wgray_meta_ff;
        end
    end

endmodule

// ==== flash_front.sv ====
`timescale 1ns/1ps
module flash_front (
    input  wire logic                        clk_sys_in,
    input  wire logic                        rst_b_in,
    input  wire logic                        spi_clk_in,
    input  wire logic                        cs_b_in,
    input  wire logic [3:0]                  data_line_in,
    output logic [3:0]                       data_line_out,
    output logic [3:0]                       data_line_oe_b_out,
    input  wire logic                        quad_enable_bit_in,
    input  wire logic                        busy_in,
    input  wire logic [7:0]                  fill_data_in,
    input  wire logic                        fill_valid_in,
    output logic                             fill_ready_out,
    output logic                             event_valid_out,
    output flash_front_pkg::link_event_t     event_out,
    output logic                             selected_out,
    output logic                             standby_out,
    output logic                             execute_in_place_mode_out
);
    // Link domain: frame reset
    logic                          frame_rst_b;
    logic                          paused;
    // Link domain: rising edge
    flash_front_pkg::link_state_t  state_ff;
    flash_front_pkg::link_state_t  nxt_state;
    flash_front_pkg::link_state_t  eff_state;
    logic [4:0]                    cnt_ff;
    logic [4:0]                    nxt_cnt;
    logic [23:0]                   sh_ff;
    logic [23:0]                   nxt_sh;
    logic [23:0]                   shifted;
    logic [7:0]                    opcode_ff;
    logic [7:0]                    nxt_opcode;
    logic [7:0]                    opc;
    logic                          xip_ff;
    logic                          nxt_xip;
    flash_front_pkg::link_event_t  ev_ff;
    flash_front_pkg::link_event_t  nxt_ev;
    logic                          ev_tgl_ff;
    logic                          nxt_ev_tgl;
    logic                          qe_meta_ff;
    logic                          qe_ff;
    logic                          in_x4;
    logic [4:0]                    len;
    logic                          last;
    // Link domain: falling edge
    logic [7:0]                    out_sh_ff;
    logic [7:0]                    nxt_out_sh;
    logic [2:0]                    out_cnt_ff;
    logic [2:0]                    nxt_out_cnt;
    logic [3:0]                    out_ff;
    logic [3:0]                    nxt_out;
    logic [3:0]                    drive_ff;
    logic [3:0]                    nxt_drive;
    logic                          pop_ff;
    logic                          nxt_pop;
    logic [7:0]                    byte_src;
    logic                          rd_valid;
    logic [7:0]                    rd_data;
    // System domain
    logic                          cs_meta_ff;
    logic                          cs_sync_ff;
    logic                          tgl_meta_ff;
    logic                          tgl_sync_ff;
    logic                          tgl_seen_ff;
    logic                          xip_meta_ff;
    logic                          xip_sync_ff;
    logic                          ev_valid_ff;
    logic                          nxt_ev_valid;
    flash_front_pkg::link_event_t  ev_out_ff;
    flash_front_pkg::link_event_t  nxt_ev_out;
    logic                          standby_ff;
    logic                          nxt_standby;

    assign frame_rst_b = rst_b_in && !cs_b_in;
    assign paused      = !qe_ff && !data_line_in[3];
    assign opc         = (state_ff == flash_front_pkg::ST_START && xip_ff)
                         ? flash_front_pkg::OPC_QUAD_IO : opcode_ff;

    always_comb begin
        eff_state = state_ff;
        if (state_ff == flash_front_pkg::ST_START) begin
            eff_state = xip_ff ? flash_front_pkg::ST_ADDR : flash_front_pkg::ST_OPCODE;
        end
        in_x4 = (opc == flash_front_pkg::OPC_QUAD_IO) &&
                (eff_state == flash_front_pkg::ST_ADDR || eff_state == flash_front_pkg::ST_MODE);
        shifted = in_x4 ? {sh_ff[19:0], data_line_in} : {sh_ff[22:0], data_line_in[0]};
        case (eff_state)
            flash_front_pkg::ST_ADDR:  len = in_x4 ? flash_front_pkg::CLKS_ADDR_X4
                                                   : flash_front_pkg::CLKS_ADDR_X1;
            flash_front_pkg::ST_MODE:  len = flash_front_pkg::CLKS_MODE_X4;
            flash_front_pkg::ST_DUMMY: len = (opc == flash_front_pkg::OPC_QUAD_IO)
                                             ? flash_front_pkg::CLKS_DUMMY_QIO
                                             : flash_front_pkg::CLKS_DUMMY_FAST;
            default:                   len = flash_front_pkg::CLKS_BYTE;
        endcase
        last       = (cnt_ff == len - 5'h01);
        nxt_state  = eff_state;
        nxt_cnt    = last ? 5'h00 : cnt_ff + 5'h01;
        nxt_sh     = shifted;
        nxt_opcode = opcode_ff;
        nxt_xip    = xip_ff;
        nxt_ev     = ev_ff;
        nxt_ev_tgl = ev_tgl_ff;
        case (eff_state)
            flash_front_pkg::ST_OPCODE: begin
                if (last) begin
                    nxt_opcode = shifted[7:0];
                    nxt_xip    = 1'b0;
                    case (shifted[7:0])
                        flash_front_pkg::OPC_READ,
                        flash_front_pkg::OPC_FAST_READ,
                        flash_front_pkg::OPC_DUAL_OUT: nxt_state = flash_front_pkg::ST_ADDR;
                        flash_front_pkg::OPC_QUAD_OUT,
                        flash_front_pkg::OPC_QUAD_IO: begin
                            nxt_state = qe_ff ? flash_front_pkg::ST_ADDR
                                              : flash_front_pkg::ST_IGNORE;
                        end
                        default: begin
                            nxt_state  = flash_front_pkg::ST_WBYTE;
                            nxt_ev     = '{flash_front_pkg::EV_OPCODE, shifted[7:0],
                                           24'h00_0000, 8'h00};
                            nxt_ev_tgl = !ev_tgl_ff;
                        end
                    endcase
                end
            end
            flash_front_pkg::ST_ADDR: begin
                if (last) begin
                    nxt_ev     = '{flash_front_pkg::EV_READ, opc, shifted, 8'h00};
                    nxt_ev_tgl = !ev_tgl_ff;
                    if (opc == flash_front_pkg::OPC_QUAD_IO) begin
                        nxt_state = flash_front_pkg::ST_MODE;
                    end else if (opc == flash_front_pkg::OPC_READ) begin
                        nxt_state = flash_front_pkg::ST_DATA;
                    end else begin
                        nxt_state = flash_front_pkg::ST_DUMMY;
                    end
                end
            end
            flash_front_pkg::ST_MODE: begin
                if (last) begin
                    nxt_xip   = (shifted[flash_front_pkg::XIP_KEY_LSB +: 2]
                                 == flash_front_pkg::XIP_KEY);
                    nxt_state = flash_front_pkg::ST_DUMMY;
                end
            end
            flash_front_pkg::ST_DUMMY: begin
                if (last) begin
                    nxt_state = flash_front_pkg::ST_DATA;
                end
            end
            flash_front_pkg::ST_WBYTE: begin
                if (last) begin
                    nxt_ev     = '{flash_front_pkg::EV_WBYTE, opcode_ff, 24'h00_0000,
                                   shifted[7:0]};
                    nxt_ev_tgl = !ev_tgl_ff;
                end
            end
            default: begin
                nxt_cnt = cnt_ff;
            end
        endcase
        if (paused) begin
            nxt_state  = state_ff;
            nxt_cnt    = cnt_ff;
            nxt_sh     = sh_ff;
            nxt_opcode = opcode_ff;
            nxt_xip    = xip_ff;
            nxt_ev     = ev_ff;
            nxt_ev_tgl = ev_tgl_ff;
        end
    end

    always_ff @(posedge spi_clk_in or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            state_ff <= flash_front_pkg::ST_START;
            cnt_ff   <= 5'h00;
            sh_ff    <= 24'h00_0000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            sh_ff    <= nxt_sh;
        end
    end

    always_ff @(posedge spi_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            opcode_ff  <= 8'h00;
            xip_ff     <= 1'b0;
            ev_ff      <= '0;
            ev_tgl_ff  <= 1'b0;
            qe_meta_ff <= 1'b0;
            qe_ff      <= 1'b0;
        end else begin
            opcode_ff  <= frame_rst_b ? nxt_opcode : opcode_ff;
            xip_ff     <= frame_rst_b ? nxt_xip : xip_ff;
            ev_ff      <= frame_rst_b ? nxt_ev : ev_ff;
            ev_tgl_ff  <= frame_rst_b ? nxt_ev_tgl : ev_tgl_ff;
            qe_meta_ff <= quad_enable_bit_in;
            qe_ff      <= qe_meta_ff;
        end
    end

    always_comb begin
        byte_src    = rd_valid ? rd_data : flash_front_pkg::UNDERRUN_FILL;
        nxt_out_sh  = out_sh_ff;
        nxt_out_cnt = out_cnt_ff;
        nxt_out     = out_ff;
        nxt_drive   = drive_ff;
        nxt_pop     = 1'b0;
        if (state_ff == flash_front_pkg::ST_DATA && !paused) begin
            if (out_cnt_ff == 3'h0) begin
                nxt_pop = rd_valid;
            end
            if (opc == flash_front_pkg::OPC_DUAL_OUT) begin
                nxt_drive = 4'h3;
                if (out_cnt_ff == 3'h0) begin
                    nxt_out     = {2'h0, byte_src[7:6]};
                    nxt_out_sh  = {byte_src[5:0], 2'h0};
                    nxt_out_cnt = 3'h3;
                end else begin
                    nxt_out     = {2'h0, out_sh_ff[7:6]};
                    nxt_out_sh  = {out_sh_ff[5:0], 2'h0};
                    nxt_out_cnt = out_cnt_ff - 3'h1;
                end
            end else if (opc == flash_front_pkg::OPC_QUAD_OUT ||
                         opc == flash_front_pkg::OPC_QUAD_IO) begin
                nxt_drive = 4'hF;
                if (out_cnt_ff == 3'h0) begin
                    nxt_out     = byte_src[7:4];
                    nxt_out_sh  = {byte_src[3:0], 4'h0};
                    nxt_out_cnt = 3'h1;
                end else begin
                    nxt_out     = out_sh_ff[7:4];
                    nxt_out_sh  = {out_sh_ff[3:0], 4'h0};
                    nxt_out_cnt = out_cnt_ff - 3'h1;
                end
            end else begin
                nxt_drive = 4'h2;
                if (out_cnt_ff == 3'h0) begin
                    nxt_out     = {2'h0, byte_src[7], 1'b0};
                    nxt_out_sh  = {byte_src[6:0], 1'b0};
                    nxt_out_cnt = 3'h7;
                end else begin
                    nxt_out     = {2'h0, out_sh_ff[7], 1'b0};
                    nxt_out_sh  = {out_sh_ff[6:0], 1'b0};
                    nxt_out_cnt = out_cnt_ff - 3'h1;
                end
            end
        end
    end

    always_ff @(negedge spi_clk_in or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            out_sh_ff  <= 8'h00;
            out_cnt_ff <= 3'h0;
            out_ff     <= 4'h0;
            drive_ff   <= 4'h0;
            pop_ff     <= 1'b0;
        end else begin
            out_sh_ff  <= nxt_out_sh;
            out_cnt_ff <= nxt_out_cnt;
            out_ff     <= nxt_out;
            drive_ff   <= nxt_drive;
            pop_ff     <= nxt_pop;
        end
    end

    assign data_line_out      = out_ff;
    assign data_line_oe_b_out = ~(drive_ff & {4{!paused}});

    cdc_fifo #(
        .WIDTH (flash_front_pkg::BYTE_BITS),
        .DEPTH (flash_front_pkg::FIFO_DEPTH)
    ) u_fill_fifo (
        .wr_clk_in    (clk_sys_in),
        .wr_rst_b_in  (rst_b_in),
        .wr_clear_in  (cs_sync_ff),
        .wr_valid_in  (fill_valid_in),
        .wr_data_in   (fill_data_in),
        .wr_ready_out (fill_ready_out),
        .rd_clk_in    (spi_clk_in),
        .rd_rst_b_in  (frame_rst_b),
        .rd_ready_in  (pop_ff),
        .rd_valid_out (rd_valid),
        .rd_data_out  (rd_data)
    );

    always_comb begin
        nxt_ev_valid = (tgl_sync_ff != tgl_seen_ff);
        nxt_ev_out   = nxt_ev_valid ? ev_ff : ev_out_ff;
        nxt_standby  = cs_sync_ff && !busy_in;
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cs_meta_ff  <= 1'b1;
            cs_sync_ff  <= 1'b1;
            tgl_meta_ff <= 1'b0;
            tgl_sync_ff <= 1'b0;
            tgl_seen_ff <= 1'b0;
            xip_meta_ff <= 1'b0;
            xip_sync_ff <= 1'b0;
            ev_valid_ff <= 1'b0;
            ev_out_ff   <= '0;
            standby_ff  <= 1'b0;
        end else begin
            cs_meta_ff  <= cs_b_in;
            cs_sync_ff  <= cs_meta_ff;
            tgl_meta_ff <= ev_tgl_ff;
            tgl_sync_ff <= tgl_meta_ff;
            tgl_seen_ff <= tgl_sync_ff;
            xip_meta_ff <= xip_ff;
            xip_sync_ff <= xip_meta_ff;
            ev_valid_ff <= nxt_ev_valid;
            ev_out_ff   <= nxt_ev_out;
            standby_ff  <= nxt_standby;
        end
    end

    assign event_valid_out           = ev_valid_ff;
    assign event_out                 = ev_out_ff;
    assign selected_out              = !cs_sync_ff;
    assign standby_out               = standby_ff;
    assign execute_in_place_mode_out = xip_sync_ff;

endmodule

// ==== flash_front_props.sv ====
`timescale 1ns/1ps
module flash_front_props (
    input wire logic       clk_sys_in,
    input wire logic       rst_b_in,
    input wire logic       spi_clk_in,
    input wire logic       cs_b_in,
    input wire logic [3:0] data_line_in,
    input wire logic [3:0] data_line_oe_b_out,
    input wire logic       quad_enable_bit_in,
    input wire logic       busy_in,
    input wire logic       fill_ready_out,
    input wire logic       event_valid_out,
    input wire logic       selected_out,
    input wire logic       standby_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    a_hiz_desel:
        assert property (cs_b_in |-> data_line_oe_b_out == 4'hF)
        else $error("Line driven while deselected");
    a_lane_groups:
        assert property (@(negedge spi_clk_in) disable iff (!rst_b_in || cs_b_in)
        data_line_oe_b_out inside {4'hF, 4'hD, 4'hC, 4'h0}) else $error("Bad lane group");
    a_quad_gate:
        assert property (!quad_enable_bit_in |-> &data_line_oe_b_out[3:2])
        else $error("Upper lanes driven without quad enable");
    a_pause_release:
        assert property (!quad_enable_bit_in && !data_line_in[3] |-> data_line_oe_b_out == 4'hF)
        else $error("Lines driven while paused");
    a_standby_idle:
        assert property (!selected_out && !busy_in |=> standby_out)
        else $error("No standby when idle");
    a_standby_busy:
        assert property (busy_in |=> !standby_out) else $error("Standby while busy");
    a_fill_desel:
        assert property ($rose(cs_b_in) |-> ##[1:3] !fill_ready_out)
        else $error("Fill open after deselect");
    a_sel_follow:
        assert property ($fell(cs_b_in) |-> ##[1:3] selected_out) else $error("Select late");
    a_event_pulse:
        assert property (event_valid_out |=> !event_valid_out) else $error("Event not a pulse");

    c_event: cover property (event_valid_out);
    c_quad: cover property (data_line_oe_b_out == 4'h0);
    c_dual: cover property (data_line_oe_b_out == 4'hC);
endmodule

bind flash_front flash_front_props i_flash_front_props (.clk_sys_in, .rst_b_in, .spi_clk_in,
    .cs_b_in, .data_line_in, .data_line_oe_b_out, .quad_enable_bit_in, .busy_in,
    .fill_ready_out, .event_valid_out, .selected_out, .standby_out);

// ==== host_spi_model.sv ====
`timescale 1ns/1ps
module host_spi_model (
    input  wire logic [3:0] dev_out_in,
    input  wire logic [3:0] dev_oe_b_in,
    output logic            cs_b_out,
    output logic            sck_out,
    output logic [3:0]      line_out
);
    logic [3:0] drv_v = 4'h0;
    logic [3:0] drv_en = 4'h0;
    logic       idle_hi = 1'b0;

    initial begin
        cs_b_out = 1'b1;
        sck_out = 1'b0;
    end
    // Wire level: device, host, pull-ups on 2/3, else changing pattern
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!dev_oe_b_in[i]) line_out[i] = dev_out_in[i];
            else if (drv_en[i] || i < 2) line_out[i] = drv_v[i];
            else line_out[i] = 1'b1;
        end
    end
    task automatic sel();
        sck_out = idle_hi;
        #6 cs_b_out = 1'b0;
        #6;
    endtask
    task automatic desel();
        sck_out = idle_hi;
        drv_en = 4'h0;
        #6 cs_b_out = 1'b1;
        #12;
    endtask
    task automatic tick(input logic [3:0] v, input logic [3:0] en, output logic [3:0] g);
        sck_out = 1'b0;
        drv_v = (v & en) | (~drv_v & ~en);
        drv_en = en;
        #6 g = line_out;
        sck_out = 1'b1;
        #6;
    endtask
    task automatic tx(input logic [31:0] d, input int n, input int w);
        logic [3:0] m;
        logic [3:0] g;
        m = 4'((1 << w) - 1);
        for (int i = n - w; i >= 0; i -= w) tick(4'(d >> i) & m, m, g);
    endtask
    task automatic rx(input int n, input int w, output logic [31:0] r);
        logic [3:0] g;
        r = 32'h0;
        repeat (n) begin
            tick(4'h0, 4'h0, g);
            r = (r << w) | 32'(w == 1 ? {3'h0, g[1]} : g & 4'((1 << w) - 1));
        end
    endtask
    task automatic pause(input logic lvl);
        sck_out = 1'b0;
        #3 drv_v[3] = lvl;
        drv_en[3] = 1'b1;
        #3;
    endtask
endmodule

// ==== flash_front_tb_top.sv ====
`timescale 1ns/1ps
module flash_front_tb_top;
    logic                         clk_sys_in = 1'b0;
    logic                         rst_b_in = 1'b0;
    logic                         quad_enable_bit_in = 1'b0;
    logic                         busy_in = 1'b0;
    logic [7:0]                   fill_data_in = 8'h00;
    logic                         fill_valid_in = 1'b0;
    logic                         fill_ready_out, event_valid_out, selected_out;
    logic                         standby_out, execute_in_place_mode_out;
    logic                         spi_clk_in, cs_b_in;
    logic [3:0]                   data_line_in, data_line_out, data_line_oe_b_out;
    flash_front_pkg::link_event_t event_out, ev;
    logic [7:0]                   fq[$];
    logic                         fire = 1'b0;
    logic [31:0]                  r;
    int                           miscompares = 0;
    int                           num_checks = 0;

    always #5 clk_sys_in = ~clk_sys_in;
    flash_front i_flash_front (.clk_sys_in, .rst_b_in, .spi_clk_in, .cs_b_in, .data_line_in,
        .data_line_out, .data_line_oe_b_out, .quad_enable_bit_in, .busy_in, .fill_data_in,
        .fill_valid_in, .fill_ready_out, .event_valid_out, .event_out, .selected_out,
        .standby_out, .execute_in_place_mode_out);
    host_spi_model i_host_spi_model (.dev_out_in(data_line_out),
        .dev_oe_b_in(data_line_oe_b_out), .cs_b_out(cs_b_in), .sck_out(spi_clk_in),
        .line_out(data_line_in));

    always @(negedge clk_sys_in) begin
        if (event_valid_out === 1'b1) ev = event_out;
        fire = fill_valid_in && fill_ready_out === 1'b1;
    end
    always @(posedge clk_sys_in) begin
        if (fire) void'(fq.pop_front());
        #1 fill_valid_in = fq.size() > 0;
        fill_data_in = fq.size() > 0 ? fq[0] : 8'h00;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic t_quad();
        quad_enable_bit_in = 1'b1;
        cyc(2);
        fq = '{8'hA5, 8'h3C, 8'h96, 8'h0F};
        i_host_spi_model.sel();
        i_host_spi_model.tx(32'(flash_front_pkg::OPC_QUAD_IO), 8, 1);
        i_host_spi_model.tx(32'h0012_3456, 24, 4);
        i_host_spi_model.tx(32'h0000_0020, 8, 4);
        i_host_spi_model.rx(4, 4, r);
        i_host_spi_model.rx(8, 4, r);
        chk(r, 32'hA53C_960F);
        chk(32'(data_line_oe_b_out), 32'h0000_0000);
        i_host_spi_model.desel();
        cyc(6);
        chk(32'(ev.kind), 32'(flash_front_pkg::EV_READ));
        chk(32'(ev.addr), 32'h0012_3456);
        chk(32'(execute_in_place_mode_out), 32'h0000_0001);
        $display("Quad read test done");
    endtask
    task automatic t_xip();
        fq = '{8'h5A, 8'hC3};
        i_host_spi_model.sel();
        i_host_spi_model.tx(32'h0065_4320, 24, 4);
        i_host_spi_model.tx(32'h0000_0000, 8, 4);
        i_host_spi_model.rx(4, 4, r);
        i_host_spi_model.rx(4, 4, r);
        chk(r, 32'h0000_5AC3);
        i_host_spi_model.desel();
        cyc(6);
        chk(32'(ev.addr), 32'h0065_4320);
        chk(32'(execute_in_place_mode_out), 32'h0000_0000);
        $display("Continuous read test done");
    endtask
    task automatic t_dual();
        quad_enable_bit_in = 1'b0;
        i_host_spi_model.idle_hi = 1'b1;
        cyc(2);
        fq = '{8'h81, 8'h7E};
        i_host_spi_model.sel();
        i_host_spi_model.tx(32'(flash_front_pkg::OPC_DUAL_OUT), 8, 1);
        i_host_spi_model.tx(32'h0000_0100, 24, 1);
        i_host_spi_model.rx(8, 1, r);
        i_host_spi_model.rx(4, 2, r);
        chk(r, 32'h0000_0081);
        chk(32'(data_line_oe_b_out), 32'h0000_000C);
        i_host_spi_model.pause(1'b0);
        #20 chk(32'(data_line_oe_b_out), 32'h0000_000F);
        i_host_spi_model.pause(1'b1);
        i_host_spi_model.rx(4, 2, r);
        chk(r, 32'h0000_007E);
        i_host_spi_model.desel();
        i_host_spi_model.idle_hi = 1'b0;
        $display("Dual read test done");
    endtask
    task automatic t_refuse();
        i_host_spi_model.sel();
        i_host_spi_model.tx(32'(flash_front_pkg::OPC_QUAD_IO), 8, 1);
        i_host_spi_model.rx(16, 4, r);
        chk(32'(data_line_oe_b_out), 32'h0000_000F);
        chk(32'(selected_out), 32'h0000_0001);
        i_host_spi_model.desel();
        $display("Refused quad test done");
    endtask
    task automatic t_fast();
        fq = '{8'hC5};
        i_host_spi_model.sel();
        i_host_spi_model.tx(32'(flash_front_pkg::OPC_FAST_READ), 8, 1);
        i_host_spi_model.tx(32'h0000_0200, 24, 1);
        i_host_spi_model.rx(8, 1, r);
        i_host_spi_model.rx(8, 1, r);
        chk(r, 32'h0000_00C5);
        chk(32'(data_line_oe_b_out), 32'h0000_000D);
        i_host_spi_model.desel();
        i_host_spi_model.sel();
        i_host_spi_model.tx(32'h0000_5CA7, 16, 1);
        i_host_spi_model.desel();
        cyc(6);
        chk(32'(ev.kind), 32'(flash_front_pkg::EV_WBYTE));
        chk(32'(ev.data), 32'h0000_00A7);
        $display("Fast read and write byte test done");
    endtask
    task automatic t_idle();
        ev = '0;
        i_host_spi_model.tx(32'h0000_EB12, 16, 1);
        cyc(6);
        chk(32'(ev), 32'h0000_0000);
        chk(32'(ev >> 32), 32'h0000_0000);
        chk(32'(data_line_oe_b_out), 32'h0000_000F);
        chk(32'(selected_out), 32'h0000_0000);
        busy_in = 1'b1;
        cyc(3);
        chk(32'(standby_out), 32'h0000_0000);
        busy_in = 1'b0;
        cyc(3);
        chk(32'(standby_out), 32'h0000_0001);
        $display("Deselected test done");
    endtask

    initial begin
        cyc(3);
        rst_b_in = 1'b1;
        cyc(3);
        t_quad();
        t_xip();
        t_dual();
        t_refuse();
        t_fast();
        t_idle();
        stop_test();
    end
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule
